// ---- wake_pkg.sv ----
package wake_pkg;
  // register offsets (byte addresses on the plain port)
  localparam logic [7:0] ADDR_LEVEL_A   = 8'h00;
  localparam logic [7:0] ADDR_LEVEL_B   = 8'h04;
  localparam logic [7:0] ADDR_REQ_CLEAR = 8'h08;
  localparam logic [7:0] ADDR_NMI_CAUSE = 8'h0C;
  localparam logic [7:0] ADDR_RST_CAUSE = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STAT  = 8'h14;
  localparam logic [7:0] ADDR_IRQ_MASK  = 8'h18;

  localparam int NUM_SRC     = 8;
  localparam int LANE_W      = 8;
  // lane field positions
  localparam int POS_ENABLE  = 0;
  localparam int POS_UNDEF   = 1;
  localparam int POS_EDGE    = 2;
  localparam int POS_LEVEL   = 4;
  localparam int POS_TOP     = 7;
  localparam int RTC_INDEX   = 7;

  typedef enum logic [2:0] {
    LVL_LOW     = 3'h0,
    LVL_HIGH    = 3'h1,
    LVL_FALL    = 3'h2,
    LVL_RISE    = 3'h3,
    LVL_BOTH    = 3'h4
  } level_sel_t;

  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;

  localparam logic [4:0] CLR_CODE_MAX = 5'h07;

  // nmi and reset cause bit positions
  localparam int NMI_WDOG_BIT = 0;
  localparam int NMI_LVD_BIT  = 2;
  localparam int RST_PIN_BIT  = 0;
  localparam int RST_OSC_BIT  = 1;
  localparam int RST_WDOG_BIT = 2;
  localparam int RST_STOP_BIT = 3;
  localparam int RST_SYS_BIT  = 4;
  localparam int RST_LVD_BIT  = 6;
  localparam logic [7:0] RST_WRITABLE = 8'h5D;
  localparam logic [7:0] RST_RESET    = 8'h01;
  localparam logic [31:0] UNDEF_FILL  = 32'h00000000; // arbitrary value for undefined bits
endpackage : wake_pkg

// ---- wake_src_if.sv ----
`timescale 1ns/1ps
// per-source configuration and status between top and detector
interface wake_src_if;
  logic [2:0] level_sel;
  logic       enable;
  logic       clear;
  logic [1:0] edge_stat;
  logic       pending;
  logic       fired;
  modport ctrl (output level_sel, output enable, output clear, input edge_stat, input pending, input fired);
  modport det  (input level_sel, input enable, input clear, output edge_stat, output pending, output fired);
endinterface : wake_src_if

// ---- wake_detect.sv ----
`timescale 1ns/1ps
module wake_detect (
  // clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // raw wake pin
  input  wire logic pin,
  // control and status
  wake_src_if.det   src
);
  logic [2:0] sync_q, sync_d;
  logic       last_q, last_d;
  logic [1:0] edge_q, edge_d;
  logic       pend_q, pend_d;
  logic       rise, fall, hit;

  // three-stage synchroniser; stable value is taken when stages two and three agree
  always_comb begin
    sync_d = {sync_q[1:0], pin};
    last_d = (sync_q[2] == sync_q[1]) ? sync_q[2] : last_q;
    rise   = (sync_q[2] == sync_q[1]) && sync_q[2] && !last_q;
    fall   = (sync_q[2] == sync_q[1]) && !sync_q[2] && last_q;
    unique case (src.level_sel)
      3'(wake_pkg::LVL_LOW):  hit = !last_q;
      3'(wake_pkg::LVL_HIGH): hit = last_q;
      3'(wake_pkg::LVL_FALL): hit = fall;
      3'(wake_pkg::LVL_RISE): hit = rise;
      3'(wake_pkg::LVL_BOTH): hit = rise | fall;
      default:                hit = 1'b0;             // prohibited codes never fire
    endcase
    edge_d = edge_q;
    pend_d = pend_q;
    // clear first so a same-cycle event wins
    if (src.clear) begin
      edge_d = wake_pkg::EDGE_NONE;
      pend_d = 1'b0;
    end
    if (hit && src.enable) begin
      pend_d = 1'b1;                                   // held until cleared
      if (src.level_sel == 3'(wake_pkg::LVL_BOTH)) begin
        edge_d = edge_d | (rise ? wake_pkg::EDGE_RISE : wake_pkg::EDGE_FALL);
      end
    end
  end

  // registers; reset leaves nothing pending
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync_q <= 3'h0;
      last_q <= 1'b0;
      edge_q <= wake_pkg::EDGE_NONE;
      pend_q <= 1'b0;
    end else begin
      sync_q <= sync_d;
      last_q <= last_d;
      edge_q <= edge_d;
      pend_q <= pend_d;
    end
  end

  assign src.edge_stat = edge_q;
  assign src.pending   = pend_q;
  assign src.fired     = hit && src.enable;

  a_clear_drops_edge: assert property (@(posedge clk) disable iff (sys_rst)
    src.clear && !(hit && src.enable) |=> edge_q == wake_pkg::EDGE_NONE && !pend_q)
    else $error("clear did not drop edge status");
  a_disabled_no_pend: assert property (@(posedge clk) disable iff (sys_rst)
    !pend_q && !src.enable |=> !pend_q)
    else $error("disabled source became pending");
  a_pending_held: assert property (@(posedge clk) disable iff (sys_rst)
    pend_q && !src.clear |=> pend_q)
    else $error("pending request dropped without a clear");
endmodule : wake_detect

// ---- wake_reset_flags.sv ----
`timescale 1ns/1ps
module wake_reset_flags (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // wake pins: seven external, rtc last
  input  wire logic [6:0]  ext_wake_pin,
  input  wire logic        rtc_wake_source,
  // reset and nmi causes, same-clock level inputs
  input  wire logic        pin_reset_seen,
  input  wire logic        watchdog_reset_seen,
  input  wire logic        deep_stop_reset_seen,
  input  wire logic        system_reset_request,
  input  wire logic        low_voltage_reset_seen,
  input  wire logic        oscillator_flash_permit,
  input  wire logic        nmi_from_watchdog,
  input  wire logic        nmi_from_low_voltage,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // wake outputs
  output logic             wake_request,
  output logic      [7:0]  wake_pending,
  output logic             irq
);

  wake_src_if srcs [wake_pkg::NUM_SRC] ();
  logic [7:0]  pins;
  logic [2:0]  lvl_q [wake_pkg::NUM_SRC];
  logic [2:0]  lvl_d [wake_pkg::NUM_SRC];
  logic [7:0]  en_q, en_d, clr_vec;
  logic [7:0]  nmi_q, nmi_d, rst_q, rst_d;
  logic [7:0]  stat_q, stat_d, mask_q, mask_d;
  logic [31:0] rdata_q, rdata_d;
  logic [7:0]  fired, edge_pend;

  assign pins = {rtc_wake_source, ext_wake_pin};

  // one lane of a control register
  function automatic logic [7:0] lane(input logic [2:0] l, input logic [1:0] e, input logic en);
    lane = {1'b0, l, e, wake_pkg::UNDEF_FILL[0], en}; // top bit zero, bit 1 undefined
  endfunction : lane

  genvar g;
  generate
    for (g = 0; g < wake_pkg::NUM_SRC; g++) begin : g_src
      assign srcs[g].level_sel = lvl_q[g];
      assign srcs[g].enable    = en_q[g];
      assign srcs[g].clear     = clr_vec[g];
      assign fired[g]          = srcs[g].fired;
      assign edge_pend[g]      = srcs[g].pending;
      wake_detect u_det (
        .clk     (clk),
        .sys_rst (sys_rst),
        .pin     (pins[g]),
        .src     (srcs[g])
      );
    end
  endgenerate

  // decode of the encoded clear field
  always_comb begin
    clr_vec = 8'h00;
    if (reg_wr && reg_addr == wake_pkg::ADDR_REQ_CLEAR && reg_wdata[4:0] <= wake_pkg::CLR_CODE_MAX) begin
      clr_vec[reg_wdata[2:0]] = 1'b1;
    end
  end

  // control register next state; each source is one byte lane
  always_comb begin
    en_d = en_q;
    for (int i = 0; i < wake_pkg::NUM_SRC; i++) begin
      lvl_d[i] = lvl_q[i];
      if (reg_wr && reg_addr == ((i < 4) ? wake_pkg::ADDR_LEVEL_A : wake_pkg::ADDR_LEVEL_B)) begin
        // level and enable both taken as written; ordering is left to software
        lvl_d[i] = reg_wdata[(i % 4) * wake_pkg::LANE_W + wake_pkg::POS_LEVEL +: 3];
        en_d[i]  = reg_wdata[(i % 4) * wake_pkg::LANE_W + wake_pkg::POS_ENABLE];
      end
    end
  end

  // cause flags: nmi flags follow their inputs; reset flags: set wins over software clear, writing 0
  always_comb begin
    nmi_d = 8'h00;
    nmi_d[wake_pkg::NMI_WDOG_BIT] = nmi_from_watchdog;
    nmi_d[wake_pkg::NMI_LVD_BIT]  = nmi_from_low_voltage;
    rst_d = rst_q;
    if (reg_wr && reg_addr == wake_pkg::ADDR_RST_CAUSE) begin
      rst_d = rst_q & (reg_wdata[7:0] | ~wake_pkg::RST_WRITABLE);
    end
    rst_d[wake_pkg::RST_PIN_BIT]  = rst_d[wake_pkg::RST_PIN_BIT]  | pin_reset_seen;
    rst_d[wake_pkg::RST_WDOG_BIT] = rst_d[wake_pkg::RST_WDOG_BIT] | watchdog_reset_seen;
    rst_d[wake_pkg::RST_STOP_BIT] = rst_d[wake_pkg::RST_STOP_BIT] | deep_stop_reset_seen;
    rst_d[wake_pkg::RST_SYS_BIT]  = rst_d[wake_pkg::RST_SYS_BIT]  | system_reset_request;
    rst_d[wake_pkg::RST_LVD_BIT]  = rst_d[wake_pkg::RST_LVD_BIT]  | low_voltage_reset_seen;
    rst_d[wake_pkg::RST_OSC_BIT]  = oscillator_flash_permit;      // live, read-only
  end

  // interrupt status: events set, a read clears, set wins
  always_comb begin
    stat_d = stat_q;
    mask_d = mask_q;
    if (reg_rd && reg_addr == wake_pkg::ADDR_IRQ_STAT) begin
      stat_d = 8'h00;
    end
    stat_d = stat_d | fired;
    if (reg_wr && reg_addr == wake_pkg::ADDR_IRQ_MASK) begin
      mask_d = reg_wdata[7:0];
    end
  end

  // read mux; unmapped and write-only addresses read zero
  always_comb begin
    rdata_d = 32'h00000000;
    if (reg_rd) begin
      unique case (reg_addr)
        wake_pkg::ADDR_LEVEL_A:
          rdata_d = {lane(lvl_q[3], srcs[3].edge_stat, en_q[3]), lane(lvl_q[2], srcs[2].edge_stat, en_q[2]),
                     lane(lvl_q[1], srcs[1].edge_stat, en_q[1]), lane(lvl_q[0], srcs[0].edge_stat, en_q[0])};
        wake_pkg::ADDR_LEVEL_B:
          rdata_d = {lane(lvl_q[7], srcs[7].edge_stat, en_q[7]), lane(lvl_q[6], srcs[6].edge_stat, en_q[6]),
                     lane(lvl_q[5], srcs[5].edge_stat, en_q[5]), lane(lvl_q[4], srcs[4].edge_stat, en_q[4])};
        wake_pkg::ADDR_NMI_CAUSE: rdata_d = {24'h000000, nmi_q};
        wake_pkg::ADDR_RST_CAUSE: rdata_d = {24'h000000, rst_q};
        wake_pkg::ADDR_IRQ_STAT:  rdata_d = {24'h000000, stat_q};
        wake_pkg::ADDR_IRQ_MASK:  rdata_d = {24'h000000, mask_q};
        default:                  rdata_d = 32'h00000000;
      endcase
    end
  end

  // registers; reset flag register keeps its pin flag set after reset
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < wake_pkg::NUM_SRC; i++) begin
        lvl_q[i] <= 3'(wake_pkg::LVL_FALL);
      end
      en_q    <= 8'h00;
      nmi_q   <= 8'h00;
      rst_q   <= wake_pkg::RST_RESET;
      stat_q  <= 8'h00;
      mask_q  <= 8'h00;
      rdata_q <= 32'h00000000;
    end else begin
      lvl_q   <= lvl_d;
      en_q    <= en_d;
      nmi_q   <= nmi_d;
      rst_q   <= rst_d;
      stat_q  <= stat_d;
      mask_q  <= mask_d;
      rdata_q <= rdata_d;
    end
  end

  // reg_rdata and wake_pending straight from flops, wake_request and irq ORed from flops; an unsupported rtc setting is not trapped, software must avoid it
  assign reg_rdata    = rdata_q;
  assign wake_pending = edge_pend;
  assign wake_request = |edge_pend;
  assign irq          = |(stat_q & mask_q);

  a_rst_hold_flags: assert property (@(posedge clk) disable iff (sys_rst)
    rst_q[wake_pkg::RST_WDOG_BIT] && !(reg_wr && reg_addr == wake_pkg::ADDR_RST_CAUSE) |=> rst_q[wake_pkg::RST_WDOG_BIT])
    else $error("reset flag cleared without a write");
  a_rst_set_flag: assert property (@(posedge clk) disable iff (sys_rst)
    low_voltage_reset_seen |=> rst_q[wake_pkg::RST_LVD_BIT])
    else $error("low voltage reset flag not set");
  a_osc_flag_live: assert property (@(posedge clk) disable iff (sys_rst)
    ##1 rst_q[wake_pkg::RST_OSC_BIT] == $past(oscillator_flash_permit))
    else $error("oscillator flag does not follow input");
  a_nmi_wdog_flag: assert property (@(posedge clk) disable iff (sys_rst)
    nmi_from_watchdog |=> nmi_q[wake_pkg::NMI_WDOG_BIT])
    else $error("watchdog nmi flag missing");
  a_nmi_lvd_flag: assert property (@(posedge clk) disable iff (sys_rst)
    nmi_from_low_voltage |=> nmi_q[wake_pkg::NMI_LVD_BIT])
    else $error("low voltage nmi flag missing");
  a_clear_bad_code: assert property (@(posedge clk) disable iff (sys_rst)
    reg_wr && reg_addr == wake_pkg::ADDR_REQ_CLEAR && reg_wdata[4:3] != 2'h0 |-> clr_vec == 8'h00)
    else $error("prohibited clear code acted");
  a_lane_top_zero: assert property (@(posedge clk) disable iff (sys_rst)
    $past(reg_rd) && $past(reg_addr) == wake_pkg::ADDR_LEVEL_A |-> reg_rdata[31] == 1'b0 && reg_rdata[7] == 1'b0)
    else $error("lane top bit not zero");
  a_level_written: assert property (@(posedge clk) disable iff (sys_rst)
    reg_wr && reg_addr == wake_pkg::ADDR_LEVEL_A |=> lvl_q[0] == $past(reg_wdata[6:4]))
    else $error("level select not stored");
  a_rst_write_one: assert property (@(posedge clk) disable iff (sys_rst)
    reg_wr && reg_addr == wake_pkg::ADDR_RST_CAUSE && reg_wdata[wake_pkg::RST_LVD_BIT] && rst_q[wake_pkg::RST_LVD_BIT]
    |=> rst_q[wake_pkg::RST_LVD_BIT])
    else $error("writing one changed a reset flag");
  a_rst_write_zero: assert property (@(posedge clk) disable iff (sys_rst)
    reg_wr && reg_addr == wake_pkg::ADDR_RST_CAUSE && !reg_wdata[wake_pkg::RST_PIN_BIT] && !pin_reset_seen
    |=> !rst_q[wake_pkg::RST_PIN_BIT])
    else $error("writing zero left a reset flag set");
  a_nmi_wdog_drop: assert property (@(posedge clk) disable iff (sys_rst)
    !nmi_from_watchdog |=> !nmi_q[wake_pkg::NMI_WDOG_BIT])
    else $error("watchdog nmi flag outlived its source");
  a_enable_written: assert property (@(posedge clk) disable iff (sys_rst)
    reg_wr && reg_addr == wake_pkg::ADDR_LEVEL_B
    |=> en_q[wake_pkg::RTC_INDEX] == $past(reg_wdata[3 * wake_pkg::LANE_W + wake_pkg::POS_ENABLE]))
    else $error("enable bit not stored");
endmodule : wake_reset_flags

// ---- wake_pin_model.sv ----
`timescale 1ns/1ps
// far side: seven wake pins and the rtc wake line
module wake_pin_model (
  // clock
  input  wire logic       clk,
  // levels asked for by the bench
  input  wire logic [7:0] want,
  // pins toward the block
  output logic      [6:0] ext_wake_pin,
  output logic            rtc_wake_source
);
  // rtc idles high; the bench drives it low and later high again
  initial begin
    ext_wake_pin    = 7'h00;
    rtc_wake_source = 1'b1;
  end
  // pins move just after an edge, never on the sampling instant
  always @(posedge clk) begin
    ext_wake_pin    <= want[6:0];
    rtc_wake_source <= want[7];
  end
endmodule : wake_pin_model

// ---- wake_reset_flags_tb_top.sv ----
`timescale 1ns/1ps
module wake_reset_flags_tb_top;
  logic        clk;
  logic        sys_rst;
  logic [7:0]  want;
  logic [6:0]  ext_wake_pin;
  logic        rtc_wake_source;
  logic [4:0]  cause;
  logic        osc_ok;
  logic [1:0]  nmi;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic        wake_request;
  logic [7:0]  wake_pending;
  logic        irq;
  logic [31:0] shadow [2];
  int          miscompares;
  int          checked;

  wake_pin_model pins (.clk(clk), .want(want), .ext_wake_pin(ext_wake_pin), .rtc_wake_source(rtc_wake_source));
  wake_reset_flags DUT (.clk(clk), .sys_rst(sys_rst), .ext_wake_pin(ext_wake_pin),
    .rtc_wake_source(rtc_wake_source), .pin_reset_seen(cause[0]), .watchdog_reset_seen(cause[1]),
    .deep_stop_reset_seen(cause[2]), .system_reset_request(cause[3]), .low_voltage_reset_seen(cause[4]),
    .oscillator_flash_permit(osc_ok), .nmi_from_watchdog(nmi[0]), .nmi_from_low_voltage(nmi[1]),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .wake_request(wake_request), .wake_pending(wake_pending), .irq(irq));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // one-cycle strobes, launched just after an edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd
  task automatic pin(input int s, input logic v);
    @(posedge clk);
    want[s] <= v;
  endtask : pin
  // synchroniser plus detection takes a few cycles, so allow eight
  task automatic pnd(input logic [7:0] e);
    repeat (8) @(posedge clk);
    #1;
    chk({23'h0, wake_request, wake_pending}, {23'h0, |e, e});
  endtask : pnd
  // level goes in first with enable low, enable follows in its own write
  task automatic cfg(input int s, input logic [2:0] lvl, input logic en);
    int r;
    r = s / 4;
    shadow[r][8*(s%4)+:8] = {1'b0, lvl, 4'h0};
    wr(r ? wake_pkg::ADDR_LEVEL_B : wake_pkg::ADDR_LEVEL_A, shadow[r]);
    shadow[r][8*(s%4)] = en;
    if (en) wr(r ? wake_pkg::ADDR_LEVEL_B : wake_pkg::ADDR_LEVEL_A, shadow[r]);
  endtask : cfg

  task automatic t_reset;
    logic [31:0] d;
    rd(wake_pkg::ADDR_LEVEL_A, d);
    chk(d & 32'hFDFDFDFD, 32'h20202020);
    rd(wake_pkg::ADDR_LEVEL_B, d);
    chk(d & 32'hFDFDFDFD, 32'h20202020);
    rd(wake_pkg::ADDR_REQ_CLEAR, d);
    chk(d, 32'h00000000);
    rd(wake_pkg::ADDR_NMI_CAUSE, d);
    chk(d, 32'h00000000);
    rd(8'h1C, d);
    chk(d, 32'h00000000);
    pnd(8'h00);
  endtask : t_reset

  task automatic t_flags;
    logic [31:0] d;
    rd(wake_pkg::ADDR_RST_CAUSE, d);
    chk(d, 32'h00000001);
    @(posedge clk);
    cause <= 5'h1F;
    @(posedge clk);
    cause <= 5'h00;
    rd(wake_pkg::ADDR_RST_CAUSE, d);
    chk(d, 32'h0000005D);
    @(posedge clk);
    osc_ok <= 1'b1;
    rd(wake_pkg::ADDR_RST_CAUSE, d);
    chk(d, 32'h0000005F);
    wr(wake_pkg::ADDR_RST_CAUSE, 32'hFFFFFFFF);
    rd(wake_pkg::ADDR_RST_CAUSE, d);
    chk(d, 32'h0000005F);
    wr(wake_pkg::ADDR_RST_CAUSE, 32'h0000005B);
    rd(wake_pkg::ADDR_RST_CAUSE, d);
    chk(d, 32'h0000005B);
    @(posedge clk);
    osc_ok <= 1'b0;
    wr(wake_pkg::ADDR_RST_CAUSE, 32'h00000000);
    rd(wake_pkg::ADDR_RST_CAUSE, d);
    chk(d, 32'h00000000);
  endtask : t_flags

  task automatic t_nmi;
    logic [31:0] d;
    @(posedge clk);
    nmi <= 2'b11;
    rd(wake_pkg::ADDR_NMI_CAUSE, d);
    chk(d, 32'h00000005);
    @(posedge clk);
    nmi <= 2'b10;
    rd(wake_pkg::ADDR_NMI_CAUSE, d);
    chk(d, 32'h00000004);
    @(posedge clk);
    nmi <= 2'b00;
  endtask : t_nmi

  // every level code on source 0, then forbidden code 5 and a disabled source
  task automatic t_modes;
    logic        idle;
    logic [31:0] d;
    logic [7:0]  mk;
    for (int m = 0; m < 6; m++) begin
      idle = (m == 0 || m == 2);
      mk = (m == 4) ? 8'hFD : 8'hF1;
      cfg(0, m[2:0], 1'b0);
      pin(0, idle);
      wr(wake_pkg::ADDR_REQ_CLEAR, 32'h0);
      cfg(0, m[2:0], 1'b1);
      pnd(8'h00);
      pin(0, !idle);
      pnd({7'h0, m < 5});
      rd(wake_pkg::ADDR_LEVEL_A, d);
      if (m < 5) chk({24'h0, d[7:0] & mk}, {24'h0, {1'b0, m[2:0], 2'b01, 2'b01} & mk});
      pin(0, idle);
      pnd({7'h0, m < 5});
      rd(wake_pkg::ADDR_LEVEL_A, d);
      if (m == 4) chk({30'h0, d[3:2]}, 32'h3);
      wr(wake_pkg::ADDR_REQ_CLEAR, 32'h0);
      pnd(8'h00);
      rd(wake_pkg::ADDR_LEVEL_A, d);
      if (m == 4) chk({30'h0, d[3:2]}, 32'h0);
    end
    cfg(0, wake_pkg::LVL_RISE, 1'b0);
    pin(0, 1'b0);
    pin(0, 1'b1);
    pnd(8'h00);
  endtask : t_modes

  task automatic t_clear;
    logic [31:0] d;
    pin(2, 1'b1);
    cfg(2, wake_pkg::LVL_FALL, 1'b1);
    cfg(7, wake_pkg::LVL_FALL, 1'b1);
    pin(2, 1'b0);
    pin(7, 1'b0);
    for (int c = 8; c < 32; c++) wr(wake_pkg::ADDR_REQ_CLEAR, c);
    pnd(8'h84);
    wr(wake_pkg::ADDR_REQ_CLEAR, 32'h7);
    pnd(8'h04);
    wr(wake_pkg::ADDR_REQ_CLEAR, 32'h2);
    pin(7, 1'b1);
    pnd(8'h00);
    rd(wake_pkg::ADDR_REQ_CLEAR, d);
    chk(d, 32'h0);
  endtask : t_clear

  task automatic t_irq;
    logic [31:0] d;
    chk({31'h0, irq}, 32'h0);
    rd(wake_pkg::ADDR_IRQ_STAT, d);
    chk(d & 32'hFF, 32'h85);
    wr(wake_pkg::ADDR_IRQ_MASK, 32'h1);
    rd(wake_pkg::ADDR_IRQ_MASK, d);
    chk(d, 32'h1);
    cfg(0, wake_pkg::LVL_FALL, 1'b1);
    pin(0, 1'b0);
    pnd(8'h01);
    chk({31'h0, irq}, 32'h1);
    rd(wake_pkg::ADDR_IRQ_STAT, d);
    chk(d & 32'hFF, 32'h1);
    repeat (3) @(posedge clk);
    #1;
    chk({31'h0, irq}, 32'h0);
  endtask : t_irq

  task automatic summarize;
    $display("comparisons %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : summarize

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // whole run is well under a thousand cycles; ten thousand means a hang
  initial begin
    #100us;
    miscompares++;
    summarize;
  end
  initial begin
    sys_rst = 1'b1;
    want = 8'h80;
    cause = 5'h00;
    osc_ok = 1'b0;
    nmi = 2'b00;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    shadow[0] = 32'h20202020;
    shadow[1] = 32'h20202020;
    miscompares = 0;
    checked = 0;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset;
    t_flags;
    t_nmi;
    t_modes;
    t_clear;
    t_irq;
    summarize;
  end
endmodule : wake_reset_flags_tb_top
